// ---- src/pnsr_consts.vh ----
// Constants for the next page transmit and PHY summary status register bank.
// Assumes the includer uses register indices; byte address = index * 4.
`ifndef PNSR_CONSTS_VH
`define PNSR_CONSTS_VH

// Register indices (byte address is four times the index)
`define PNSR_IDX_EXPANSION 6'h06
`define PNSR_IDX_NEXT_PAGE 6'h07
`define PNSR_IDX_SUMMARY 6'h10
`define PNSR_IDX_FALSE_CARRIER 6'h14
`define PNSR_IDX_RX_ERROR 6'h15
`define PNSR_IDX_TENBASE 6'h1a
`define PNSR_IDX_IRQ_STATUS 6'h20
`define PNSR_IDX_IRQ_MASK 6'h21

// Next page transmit fields
`define PNSR_NP_COMPLY_ACKNOWLEDGE_BIT 12
`define PNSR_NP_TOGGLE_BIT 11
`define PNSR_NP_CODE_MSB 10
`define PNSR_NP_CODE_RESET 11'h001

// Summary status fields
`define PNSR_SS_RX_ERR_BIT 13
`define PNSR_SS_POLARITY_BIT 12
`define PNSR_SS_FALSE_CAR_BIT 11
`define PNSR_SS_SIG_DET_BIT 10
`define PNSR_SS_DESCR_LOCK_BIT 9
`define PNSR_SS_PAGE_RX_BIT 8

// Other registers' fields
`define PNSR_EXP_PAGE_RX_BIT 1
`define PNSR_TEN_POLARITY_BIT 4

// Interrupt status bit positions
`define PNSR_IRQ_RX_ERR 0
`define PNSR_IRQ_FALSE_CAR 1
`define PNSR_IRQ_PAGE_RX 2
`define PNSR_IRQ_POLARITY 3
`define PNSR_IRQ_SIG_LOST 4
`define PNSR_IRQ_LOCK_LOST 5
`define PNSR_IRQ_WIDTH 6

// Counter saturation value
`define PNSR_CNT_MAX 8'hff

`endif

// ---- src/pnsr_sync.v ----
// Two flip-flop synchroniser for a bus of independent levels.
// Assumes each bit is a slow level; multi-bit coherence is not kept.
`default_nettype none

module pnsr_sync #(
    parameter WIDTH = 2
) (
    // Clock and reset
    input wire i_clk,
    input wire i_nrst,
    // Asynchronous levels in, synchronised levels out
    input wire [WIDTH-1:0] i_async,
    output reg [WIDTH-1:0] o_sync
);

    // First stage, read only by the second stage
    reg [WIDTH-1:0] meta;

    // Two stages to settle metastability
    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            meta <= {WIDTH{1'b0}};
            o_sync <= {WIDTH{1'b0}};
        end
        else
        begin
            meta <= i_async;
            o_sync <= meta;
        end
    end

endmodule

`default_nettype wire

// ---- src/pnsr_regs.v ----
// Next page transmit and PHY summary status register bank, Avalon-MM slave.
// Assumes event inputs are one-cycle pulses on i_clk; PMD levels are async.
`include "pnsr_consts.vh"
`default_nettype none

module pnsr_regs #(
    parameter CNT_WIDTH = 8
) (
    // Clock and reset
    input wire i_clk,
    input wire i_nrst,
    // Avalon-MM slave
    input wire [7:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output reg [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    // Events from receive and arbitration logic, same clock
    input wire i_rx_error,
    input wire i_false_carrier,
    input wire i_page_received,
    input wire i_lcw_exchanged,
    input wire i_lcw_toggle,
    input wire i_message_page_flag,
    // Asynchronous levels from the PMD and 10BASE-T receiver
    input wire i_signal_detect,
    input wire i_descrambler_lock,
    input wire i_polarity_inverted,
    // Next page transmit fields towards arbitration
    output reg o_comply_acknowledge,
    output reg o_tx_toggle,
    output reg [10:0] o_code_field,
    output wire o_code_is_message,
    // Interrupt
    output wire o_irq
);

    // Bus handshake state
    reg ack;
    wire req;
    wire first;
    wire [5:0] idx;

    // Latched status
    reg rx_err_latch;
    reg false_car_latch;
    reg page_rx_latch;
    reg polarity_latch;
    reg sig_dropped;
    reg lock_dropped;

    // Counters, saturating
    reg [CNT_WIDTH-1:0] rx_err_count;
    reg [CNT_WIDTH-1:0] false_car_count;

    // Interrupt registers
    reg [`PNSR_IRQ_WIDTH-1:0] irq_status;
    reg [`PNSR_IRQ_WIDTH-1:0] irq_mask;
    reg [`PNSR_IRQ_WIDTH-1:0] next_irq_status;

    // Synchronised PMD levels
    wire [2:0] pmd_sync;
    wire sig_live;
    wire lock_live;
    wire pol_live;
    reg sig_live_d;
    reg lock_live_d;

    // Decoded read and write strobes
    wire rd_first;
    wire wr_take;
    wire rd_summary;
    wire rd_expansion;
    wire rd_rx_err;
    wire rd_false_car;
    wire rd_tenbase;

    // Read word assembly
    reg [31:0] next_rdata;
    wire [15:0] summary_word;
    wire [15:0] next_page_word;

    // Saturating increment shared by both counters
    function [CNT_WIDTH-1:0] sat_inc;
        input [CNT_WIDTH-1:0] value;
        begin
            if (value == {CNT_WIDTH{1'b1}})
                sat_inc = value;
            else
                sat_inc = value + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
        end
    endfunction

    // Level inputs cross into this domain before any use
    pnsr_sync #(
        .WIDTH(3)
    ) u_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_async({i_polarity_inverted, i_descrambler_lock, i_signal_detect}),
        .o_sync(pmd_sync)
    );

    assign sig_live = pmd_sync[0];
    assign lock_live = pmd_sync[1];
    assign pol_live = pmd_sync[2];

    // One wait state: the first cycle of a request stalls
    assign req = i_avs_read | i_avs_write;
    assign first = req & ~ack;
    assign o_avs_waitrequest = first;
    assign idx = i_avs_address[7:2];

    // Reads sample and clear in the first cycle so no event slips
    // between the snapshot and the clear; data stands a cycle later.
    assign rd_first = i_avs_read & ~ack;
    assign wr_take = i_avs_write & ack;

    assign rd_summary = rd_first & (idx == `PNSR_IDX_SUMMARY);
    assign rd_expansion = rd_first & (idx == `PNSR_IDX_EXPANSION);
    assign rd_rx_err = rd_first & (idx == `PNSR_IDX_RX_ERROR);
    assign rd_false_car = rd_first & (idx == `PNSR_IDX_FALSE_CARRIER);
    assign rd_tenbase = rd_first & (idx == `PNSR_IDX_TENBASE);

    // Handshake flop: high in the accepting cycle only
    always @(posedge i_clk)
    begin
        if (!i_nrst)
            ack <= 1'b0;
        else
            ack <= first;
    end

    // Next page transmit, software-written fields
    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            o_comply_acknowledge <= 1'b0;
            o_code_field <= `PNSR_NP_CODE_RESET;
        end
        else if (wr_take && idx == `PNSR_IDX_NEXT_PAGE)
        begin
            // Byte lane 1 carries comply_acknowledge; code spans both lanes
            if (i_avs_byteenable[1])
                o_comply_acknowledge <= i_avs_writedata[`PNSR_NP_COMPLY_ACKNOWLEDGE_BIT];
            if (i_avs_byteenable[0])
                o_code_field[7:0] <= i_avs_writedata[7:0];
            if (i_avs_byteenable[1])
                o_code_field[10:8] <= i_avs_writedata[10:8];
        end
    end

    // Toggle follows arbitration only, software cannot write it
    always @(posedge i_clk)
    begin
        if (!i_nrst)
            o_tx_toggle <= 1'b0;
        else if (i_lcw_exchanged)
            o_tx_toggle <= ~i_lcw_toggle;
    end

    // Message page indication for the arbitration side, a copy of i_message_page_flag
    assign o_code_is_message = i_message_page_flag;

    // High latches; set beats a same-cycle clearing read
    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            rx_err_latch <= 1'b0;
            false_car_latch <= 1'b0;
            page_rx_latch <= 1'b0;
            polarity_latch <= 1'b0;
        end
        else
        begin
            if (i_rx_error)
                rx_err_latch <= 1'b1;
            else if (rd_rx_err)
                rx_err_latch <= 1'b0;
            if (i_false_carrier)
                false_car_latch <= 1'b1;
            else if (rd_false_car)
                false_car_latch <= 1'b0;
            // Summary reads do not clear this flag
            if (i_page_received)
                page_rx_latch <= 1'b1;
            else if (rd_expansion)
                page_rx_latch <= 1'b0;
            // Only the 10BASE-T status read clears polarity
            if (pol_live)
                polarity_latch <= 1'b1;
            else if (rd_tenbase)
                polarity_latch <= 1'b0;
        end
    end

    // Latch-low: a drop is remembered until the summary is read.
    // Reset starts dropped so both bits read zero until first read.
    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            sig_dropped <= 1'b1;
            lock_dropped <= 1'b1;
            sig_live_d <= 1'b0;
            lock_live_d <= 1'b0;
        end
        else
        begin
            // Delayed copies feed the drop interrupts
            sig_live_d <= sig_live;
            lock_live_d <= lock_live;
            if (!sig_live)
                sig_dropped <= 1'b1;
            else if (rd_summary)
                sig_dropped <= 1'b0;
            if (!lock_live)
                lock_dropped <= 1'b1;
            else if (rd_summary)
                lock_dropped <= 1'b0;
        end
    end

    // Event counters, stick at full, clear on read or take a write
    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            rx_err_count <= {CNT_WIDTH{1'b0}};
            false_car_count <= {CNT_WIDTH{1'b0}};
        end
        else
        begin
            // An event in the clearing cycle is kept as a count of one
            if (rd_rx_err)
                rx_err_count <= {{(CNT_WIDTH-1){1'b0}}, i_rx_error};
            else if (wr_take && idx == `PNSR_IDX_RX_ERROR && i_avs_byteenable[0])
                rx_err_count <= i_avs_writedata[CNT_WIDTH-1:0];
            else if (i_rx_error)
                rx_err_count <= sat_inc(rx_err_count);
            if (rd_false_car)
                false_car_count <= {{(CNT_WIDTH-1){1'b0}}, i_false_carrier};
            else if (wr_take && idx == `PNSR_IDX_FALSE_CARRIER && i_avs_byteenable[0])
                false_car_count <= i_avs_writedata[CNT_WIDTH-1:0];
            else if (i_false_carrier)
                false_car_count <= sat_inc(false_car_count);
        end
    end

    // Summary word; reserved top bits are constant zero
    assign summary_word = {
        2'b00,
        rx_err_latch,
        polarity_latch,
        false_car_latch,
        sig_live & ~sig_dropped,
        lock_live & ~lock_dropped,
        page_rx_latch,
        8'h00
    };

    // Next page word; top bits belong to other logic and read zero
    assign next_page_word = {3'b000, o_comply_acknowledge, o_tx_toggle, o_code_field};

    // Read mux; unmapped indices answer zero
    always @*
    begin
        next_rdata = 32'h0000_0000;
        case (idx)
            `PNSR_IDX_NEXT_PAGE:
                next_rdata[15:0] = next_page_word;
            `PNSR_IDX_SUMMARY:
                next_rdata[15:0] = summary_word;
            `PNSR_IDX_EXPANSION:
                next_rdata[`PNSR_EXP_PAGE_RX_BIT] = page_rx_latch;
            `PNSR_IDX_TENBASE:
                next_rdata[`PNSR_TEN_POLARITY_BIT] = polarity_latch;
            `PNSR_IDX_RX_ERROR:
                next_rdata[CNT_WIDTH-1:0] = rx_err_count;
            `PNSR_IDX_FALSE_CARRIER:
                next_rdata[CNT_WIDTH-1:0] = false_car_count;
            `PNSR_IDX_IRQ_STATUS:
                next_rdata[`PNSR_IRQ_WIDTH-1:0] = irq_status;
            `PNSR_IDX_IRQ_MASK:
                next_rdata[`PNSR_IRQ_WIDTH-1:0] = irq_mask;
            default:
                next_rdata = 32'h0000_0000;
        endcase
    end

    // Snapshot on the stalled cycle, held through the accept edge
    always @(posedge i_clk)
    begin
        if (!i_nrst)
            o_avs_readdata <= 32'h0000_0000;
        else if (rd_first)
            o_avs_readdata <= next_rdata;
    end

    // Interrupt status: write one to clear, a new event wins
    always @*
    begin
        next_irq_status = irq_status;
        if (wr_take && idx == `PNSR_IDX_IRQ_STATUS && i_avs_byteenable[0])
            next_irq_status = irq_status & ~i_avs_writedata[`PNSR_IRQ_WIDTH-1:0];
        if (i_rx_error)
            next_irq_status[`PNSR_IRQ_RX_ERR] = 1'b1;
        if (i_false_carrier)
            next_irq_status[`PNSR_IRQ_FALSE_CAR] = 1'b1;
        if (i_page_received)
            next_irq_status[`PNSR_IRQ_PAGE_RX] = 1'b1;
        if (pol_live)
            next_irq_status[`PNSR_IRQ_POLARITY] = 1'b1;
        if (sig_live_d && !sig_live)
            next_irq_status[`PNSR_IRQ_SIG_LOST] = 1'b1;
        if (lock_live_d && !lock_live)
            next_irq_status[`PNSR_IRQ_LOCK_LOST] = 1'b1;
    end

    // Interrupt status and mask registers
    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            irq_status <= {`PNSR_IRQ_WIDTH{1'b0}};
            irq_mask <= {`PNSR_IRQ_WIDTH{1'b0}};
        end
        else
        begin
            irq_status <= next_irq_status;
            if (wr_take && idx == `PNSR_IDX_IRQ_MASK && i_avs_byteenable[0])
                irq_mask <= i_avs_writedata[`PNSR_IRQ_WIDTH-1:0];
        end
    end

    // Level interrupt while any unmasked status bit is set
    assign o_irq = |(irq_status & irq_mask);

endmodule

`default_nettype wire

// ---- dv/pnsr_properties.sv ----
// Checker for the next page transmit and summary status register bank.
// Assumes it is bound to pnsr_regs and sees only that module's ports.
`default_nettype none

module pnsr_properties #(
    parameter int CNT_WIDTH = 8
) (
    // Clock, reset and register bus
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // Events, next page fields and interrupt
    input wire logic i_rx_error,
    input wire logic i_false_carrier,
    input wire logic i_page_received,
    input wire logic i_lcw_exchanged,
    input wire logic i_lcw_toggle,
    input wire logic i_message_page_flag,
    input wire logic o_comply_acknowledge,
    input wire logic o_tx_toggle,
    input wire logic [10:0] o_code_field,
    input wire logic o_code_is_message,
    input wire logic o_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    logic [5:0] idx; // Register index
    logic rd_ok; // Read accepted this edge
    logic [11:0] np_wd; // Comply_acknowledge and code lanes of write data
    logic seen_rx, seen_fc, seen_pg; // Shadow sticky flags
    assign idx = i_avs_address[7:2];
    assign rd_ok = i_avs_read & ~o_avs_waitrequest;
    assign np_wd = {i_avs_writedata[12], i_avs_writedata[10:0]};

    // Shadows clear at the stalled edge of the clearing read; an event wins
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            seen_rx <= 1'b0;
            seen_fc <= 1'b0;
            seen_pg <= 1'b0;
        end
        else
        begin
            seen_rx <= i_rx_error | (seen_rx & ~(i_avs_read & o_avs_waitrequest & idx == 6'h15));
            seen_fc <= i_false_carrier |
                (seen_fc & ~(i_avs_read & o_avs_waitrequest & idx == 6'h14));
            seen_pg <= i_page_received |
                (seen_pg & ~(i_avs_read & o_avs_waitrequest & idx == 6'h06));
        end
    end

    chk_reset_values:
    assert property (disable iff (1'b0) !i_nrst |=> o_code_field == 11'h001 &&
        !o_comply_acknowledge && !o_tx_toggle && !o_irq)
        else $error("next page fields or irq not at reset value");
    chk_np_write:
    assert property (i_avs_write && !o_avs_waitrequest && idx == 6'h07 &&
        i_avs_byteenable[1:0] == 2'b11 |=> {o_comply_acknowledge, o_code_field} == $past(np_wd))
        else $error("next page write not taken");
    chk_np_hold:
    assert property (!(i_avs_write && idx == 6'h07) |=>
        $stable({o_comply_acknowledge, o_code_field}))
        else $error("next page fields changed without a write");
    chk_toggle_invert:
    assert property (i_lcw_exchanged |=> o_tx_toggle == !$past(i_lcw_toggle))
        else $error("toggle not inverse of exchanged toggle");
    chk_toggle_hold:
    assert property (!i_lcw_exchanged |=> $stable(o_tx_toggle))
        else $error("toggle changed without an exchange");
    chk_msg_copy:
    assert property (o_code_is_message == i_message_page_flag)
        else $error("message page indication differs from flag");
    chk_rsvd_zero:
    assert property (rd_ok && idx == 6'h10 |-> o_avs_readdata[15:14] == 2'b00)
        else $error("summary reserved bits not zero");
    chk_rx_err_latch:
    assert property (rd_ok && idx == 6'h10 |-> o_avs_readdata[13] == $past(seen_rx))
        else $error("receive error latch wrong");
    chk_false_car_latch:
    assert property (rd_ok && idx == 6'h10 |-> o_avs_readdata[11] == $past(seen_fc))
        else $error("false carrier latch wrong");
    chk_page_copy:
    assert property (rd_ok && idx == 6'h10 |-> o_avs_readdata[8] == $past(seen_pg))
        else $error("summary page received wrong");
    chk_exp_page:
    assert property (rd_ok && idx == 6'h06 |-> o_avs_readdata[1] == $past(seen_pg))
        else $error("expansion page received wrong");
    chk_one_wait:
    assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("more than one wait state");

    cover property (rd_ok && idx == 6'h10 && o_avs_readdata[13]);
    cover property (i_lcw_exchanged && i_lcw_toggle);
    cover property (o_irq);
endmodule

bind pnsr_regs pnsr_properties #(.CNT_WIDTH(CNT_WIDTH)) u_props (.i_clk, .i_nrst,
    .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
    .o_avs_readdata, .o_avs_waitrequest, .i_rx_error, .i_false_carrier, .i_page_received,
    .i_lcw_exchanged, .i_lcw_toggle, .i_message_page_flag, .o_comply_acknowledge,
    .o_tx_toggle, .o_code_field, .o_code_is_message, .o_irq);

`default_nettype wire

// ---- dv/tb_phy_nextpage_status_regs.sv ----
// Self-checking bench for the next page and summary status register bank.
// Assumes the checker file is compiled with it and binds itself.
`default_nettype none

module tb_phy_nextpage_status_regs;
    timeunit 1ns;
    timeprecision 1ps;
    // Design ports; the inputs are given values at time zero
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [7:0] i_avs_address = 8'h00;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0] i_avs_byteenable = 4'hf;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    logic i_rx_error = 1'b0;
    logic i_false_carrier = 1'b0;
    logic i_page_received = 1'b0;
    logic i_lcw_exchanged = 1'b0;
    logic i_lcw_toggle = 1'b0;
    logic i_message_page_flag = 1'b0;
    logic i_signal_detect = 1'b0;
    logic i_descrambler_lock = 1'b0;
    logic i_polarity_inverted = 1'b0;
    logic o_comply_acknowledge;
    logic o_tx_toggle;
    logic [10:0] o_code_field;
    logic o_code_is_message;
    logic o_irq;
    // Bookkeeping
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [31:0] rd; // Data of the last bus read

    pnsr_regs u_dut (.i_clk, .i_nrst, .i_avs_address, .i_avs_read, .i_avs_write,
        .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
        .i_rx_error, .i_false_carrier, .i_page_received, .i_lcw_exchanged, .i_lcw_toggle,
        .i_message_page_flag, .i_signal_detect, .i_descrambler_lock, .i_polarity_inverted,
        .o_comply_acknowledge, .o_tx_toggle, .o_code_field, .o_code_is_message, .o_irq);

    // 125 MHz clock
    always #4 i_clk = ~i_clk;

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (err_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One transfer; request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [15:0] wd);
        @(posedge i_clk);
        i_avs_address <= {idx, 2'b00};
        i_avs_writedata <= {16'h0000, wd};
        i_avs_write <= wr;
        i_avs_read <= !wr;
        do
            @(posedge i_clk);
        while (o_avs_waitrequest !== 1'b0);
        rd = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask

    // Read and compare the masked lanes
    task automatic rdc(input string what, input logic [5:0] idx, input logic [15:0] exp,
        input logic [15:0] m);
        bus(1'b0, idx, 16'h0000);
        chk(what, exp, rd[15:0] & m);
    endtask

    // One-cycle pulse of {rx error, false carrier, page, exchange}
    task automatic pulse(input logic [3:0] m);
        @(posedge i_clk);
        {i_rx_error, i_false_carrier, i_page_received, i_lcw_exchanged} <= m;
        @(posedge i_clk);
        {i_rx_error, i_false_carrier, i_page_received, i_lcw_exchanged} <= 4'h0;
    endtask

    task automatic t_reset();
        chk("np_out", 16'h0001, {3'h0, o_comply_acknowledge, o_tx_toggle, o_code_field});
        rdc("np_reset", 6'h07, 16'h0001, 16'hffff);
        rdc("sum_reset", 6'h10, 16'h0000, 16'hffff);
        rdc("mask_reset", 6'h21, 16'h0000, 16'hffff);
    endtask

    task automatic t_next_page();
        bus(1'b1, 6'h07, 16'hffff);
        rdc("np_all", 6'h07, 16'h17ff, 16'hffff);
        chk("np_out", 16'h17ff, {3'h0, o_comply_acknowledge, o_tx_toggle, o_code_field});
        bus(1'b1, 6'h07, 16'h0000);
        rdc("np_none", 6'h07, 16'h0000, 16'hffff);
        // Toggle follows the inverse of each exchanged word
        for (int v = 0; v < 2; v++)
        begin
            i_lcw_toggle <= ~v[0];
            pulse(4'h1);
            rdc("toggle", 6'h07, {4'h0, v[0], 11'h000}, 16'h0800);
            i_message_page_flag <= ~v[0];
            @(posedge i_clk);
            @(posedge i_clk);
            chk("msg_page", {15'h0000, ~v[0]}, {15'h0000, o_code_is_message});
        end
    endtask

    task automatic t_reserved();
        bus(1'b1, 6'h10, 16'hffff);
        rdc("sum_rsvd", 6'h10, 16'h0000, 16'hc000);
        rdc("unmapped", 6'h3f, 16'h0000, 16'hffff);
    endtask

    // Sticky flag: set by an event, kept over summary reads, cleared by its own read
    task automatic t_flag(input string what, input logic [3:0] m, input logic [15:0] bm,
        input logic [5:0] cidx, input logic [15:0] ce, input logic [15:0] cm);
        rdc(what, 6'h10, 16'h0000, bm);
        pulse(m);
        rdc(what, 6'h10, bm, bm);
        rdc(what, 6'h10, bm, bm);
        rdc(what, cidx, ce, cm);
        rdc(what, cidx, 16'h0000, cm);
        rdc(what, 6'h10, 16'h0000, bm);
    endtask

    task automatic t_polarity();
        i_polarity_inverted <= 1'b1;
        repeat (3) @(posedge i_clk);
        rdc("polarity_set", 6'h10, 16'h1000, 16'h1000);
        i_polarity_inverted <= 1'b0;
        repeat (3) @(posedge i_clk);
        rdc("polarity_kept", 6'h10, 16'h1000, 16'h1000);
        rdc("polarity_ten", 6'h1a, 16'h0010, 16'h0010);
        rdc("polarity_clr", 6'h10, 16'h0000, 16'h1000);
    endtask

    task automatic t_latch_low();
        {i_signal_detect, i_descrambler_lock} <= 2'b11;
        repeat (3) @(posedge i_clk);
        rdc("low_first", 6'h10, 16'h0000, 16'h0600);
        rdc("low_live", 6'h10, 16'h0600, 16'h0600);
        // A short dip is held low until read, then the live level returns
        for (int k = 0; k < 2; k++)
        begin
            {i_signal_detect, i_descrambler_lock} <= k ? 2'b10 : 2'b01;
            repeat (3) @(posedge i_clk);
            {i_signal_detect, i_descrambler_lock} <= 2'b11;
            repeat (3) @(posedge i_clk);
            rdc("low_held", 6'h10, k ? 16'h0400 : 16'h0200, 16'h0600);
            rdc("low_back", 6'h10, 16'h0600, 16'h0600);
        end
    endtask

    task automatic t_irq();
        // Every source has fired by now in the earlier scenarios
        rdc("irq_all", 6'h20, 16'h003f, 16'h003f);
        bus(1'b1, 6'h20, 16'h003f);
        bus(1'b1, 6'h21, 16'h0001);
        pulse(4'h8);
        @(posedge i_clk);
        chk("irq_set", 16'h0001, {15'h0000, o_irq});
        rdc("irq_status", 6'h20, 16'h0001, 16'h003f);
        bus(1'b1, 6'h21, 16'h0000);
        @(posedge i_clk);
        chk("irq_masked", 16'h0000, {15'h0000, o_irq});
        bus(1'b1, 6'h21, 16'h0001);
        @(posedge i_clk);
        chk("irq_unmasked", 16'h0001, {15'h0000, o_irq});
        bus(1'b1, 6'h20, 16'h0001);
        @(posedge i_clk);
        chk("irq_cleared", 16'h0000, {15'h0000, o_irq});
        rdc("irq_status", 6'h20, 16'h0000, 16'h003f);
    endtask

    // Main sequence
    initial
    begin
        repeat (5) @(posedge i_clk);
        i_nrst <= 1'b1;
        t_reset();
        t_next_page();
        t_reserved();
        t_flag("rx_err", 4'h8, 16'h2000, 6'h15, 16'h0001, 16'h00ff);
        t_flag("false_car", 4'h4, 16'h0800, 6'h14, 16'h0001, 16'h00ff);
        t_flag("page_rx", 4'h2, 16'h0100, 6'h06, 16'h0002, 16'h0002);
        t_polarity();
        t_latch_low();
        t_irq();
        tally_and_finish();
    end
endmodule

`default_nettype wire
